// >>> src/sfg_pkg.sv
package sfg_pkg;

	// feature identification bit positions
	localparam int FEAT_EXT3_BIT = 0;
	localparam int FEAT_SUP3_BIT = 9;
	localparam int FEAT_P1_BIT = 19;
	localparam int FEAT_P2_BIT = 20;
	localparam int FEAT_W = 32;

	// control flag bit positions
	localparam int CTL_EMU_BIT = 2;
	localparam int CTL_TS_BIT = 3;
	localparam int CTL_NE_BIT = 5;
	localparam int CTL_W = 32;

	// fault vectors
	localparam logic [7:0] VEC_INVALID_OP = 8'h06;
	localparam logic [7:0] VEC_DEV_UNAVAIL = 8'h07;
	localparam logic [7:0] VEC_LEGACY_FP = 8'h10;
	localparam logic [7:0] VEC_SIMD_FP = 8'h13;
	localparam logic [7:0] VEC_NONE = 8'h00;

	// immediate fields
	localparam int IMM_SEL_LO = 4;
	localparam int IMM_SUPPRESS_PREC = 3;

	// reset values
	localparam logic [7:0] RST_VEC = 8'h00;

	// instruction extension class
	typedef enum logic [2:0] {
		SFG_CLS_OTHER,
		SFG_CLS_EXT3,
		SFG_CLS_SUP3,
		SFG_CLS_P1,
		SFG_CLS_P2_GATED,
		SFG_CLS_P2_FREE
	} sfg_cls_e;

	// operation kind inside a class
	typedef enum logic [2:0] {
		SFG_OP_PLAIN,
		SFG_OP_TRUNC_STORE,
		SFG_OP_DOT,
		SFG_OP_ROUND,
		SFG_OP_FP_MOVE
	} sfg_op_e;

	// numeric exception flags from the datapath
	typedef struct packed {
		logic invalid;
		logic denormal;
		logic overflow;
		logic underflow;
		logic precision;
	} sfg_nexc_s;

	// decoded instruction request
	typedef struct packed {
		logic valid;
		sfg_cls_e cls;
		sfg_op_e op;
		logic [7:0] imm;
		logic src_snan;
		logic [3:0] nan_in;
		sfg_nexc_s raw_exc;
		sfg_nexc_s elem_input_exc;
	} sfg_req_s;

	// outcome toward the pipeline
	typedef struct packed {
		logic valid;
		logic fault;
		logic [7:0] vector;
		logic commit;
		sfg_nexc_s exc;
		logic [3:0] zero_lanes;
		logic force_nan;
		logic ne_effective;
	} sfg_rsp_s;

endpackage

// >>> src/sfg_gate.sv
`timescale 1ns/1ns
module sfg_gate
	import sfg_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control and feature state
	input wire logic [CTL_W-1:0] ctl_flags,
	input wire logic [FEAT_W-1:0] feature_identification,
	input wire logic [3:0] simd_control_status_mask,
	input wire logic ignore_numeric_error_pin_n,
	// pipeline request
	input wire sfg_req_s req,
	// pipeline outcome
	output sfg_rsp_s rsp
);

	// reset release through two flops
	logic rst_s1_r;
	logic rst_s2_r;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end
		else
		begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end

	// feature presence for a class
	function automatic logic feat_ok(input sfg_cls_e c, input logic [FEAT_W-1:0] f);
		logic ok;
		ok = 1'b1;
		unique case (c)
			SFG_CLS_EXT3: ok = f[FEAT_EXT3_BIT];
			SFG_CLS_SUP3: ok = f[FEAT_SUP3_BIT];
			SFG_CLS_P1: ok = f[FEAT_P1_BIT];
			SFG_CLS_P2_GATED: ok = f[FEAT_P2_BIT];
			SFG_CLS_P2_FREE: ok = 1'b1;
			SFG_CLS_OTHER: ok = 1'b1;
			default: ok = 1'b1;
		endcase
		return ok;
	endfunction

	// classes covered by this gating
	function automatic logic is_simd(input sfg_cls_e c);
		return (c != SFG_CLS_OTHER);
	endfunction

	// flag shortcuts
	logic ts;
	logic emu;
	assign ts = ctl_flags[CTL_TS_BIT];
	assign emu = ctl_flags[CTL_EMU_BIT];

	// next outcome
	sfg_rsp_s rsp_nxt;
	sfg_rsp_s rsp_r;

	// decides the fault and numeric reporting
	always_comb
	begin
		sfg_nexc_s e;
		logic [3:0] sel;
		logic any_exc;
		e = req.raw_exc;
		sel = req.imm[IMM_SEL_LO +: 4];
		any_exc = 1'b0;
		// quiet defaults: no fault, nothing zeroed, nothing forced
		rsp_nxt = '0;
		rsp_nxt.valid = req.valid;
		rsp_nxt.vector = VEC_NONE;
		rsp_nxt.ne_effective = ctl_flags[CTL_NE_BIT];
		// only the extension classes are gated here
		if (req.valid && is_simd(req.cls))
		begin
			// opcode checks before the task-switched check
			if (!feat_ok(req.cls, feature_identification))
			begin
				rsp_nxt.fault = 1'b1;
				rsp_nxt.vector = VEC_INVALID_OP;
			end
			else if (emu)
			begin
				rsp_nxt.fault = 1'b1;
				rsp_nxt.vector = VEC_INVALID_OP;
			end
			else if (ts && req.cls != SFG_CLS_P2_FREE)
			begin
				rsp_nxt.fault = 1'b1;
				rsp_nxt.vector = VEC_DEV_UNAVAIL;
			end
			else
			begin
				// numeric exception shaping per operation
				unique case (req.op)
					SFG_OP_DOT:
					begin
						// deselected elements forced to +0, their input faults dropped
						rsp_nxt.zero_lanes = ~sel;
						e = req.raw_exc & ~req.elem_input_exc;
						rsp_nxt.force_nan = |(req.nan_in & sel);
					end
					SFG_OP_ROUND:
					begin
						e = '0;
						e.invalid = req.src_snan;
						e.precision = req.raw_exc.precision && !req.imm[IMM_SUPPRESS_PREC];
					end
					SFG_OP_FP_MOVE: e = '0;
					SFG_OP_TRUNC_STORE: e = req.raw_exc;
					SFG_OP_PLAIN: e = req.raw_exc;
					default: e = '0;
				endcase
				// supplemental and part two raise no fp errors
				if (req.cls == SFG_CLS_SUP3 || req.cls == SFG_CLS_P2_GATED
					|| req.cls == SFG_CLS_P2_FREE)
					e = '0;
				// masked conditions do not fault
				any_exc = e.invalid && !simd_control_status_mask[0];
				any_exc = any_exc || (e.denormal && !simd_control_status_mask[1]);
				any_exc = any_exc || ((e.overflow || e.underflow) && !simd_control_status_mask[2]);
				any_exc = any_exc || (e.precision && !simd_control_status_mask[3]);
				rsp_nxt.exc = e;
				if (req.op == SFG_OP_TRUNC_STORE && req.cls == SFG_CLS_EXT3)
				begin
					// legacy stack behaviour: control flag and pin honoured
					rsp_nxt.ne_effective = ctl_flags[CTL_NE_BIT];
					if (any_exc && (ctl_flags[CTL_NE_BIT] || ignore_numeric_error_pin_n))
					begin
						rsp_nxt.fault = 1'b1;
						rsp_nxt.vector = VEC_LEGACY_FP;
					end
				end
				else
				begin
					// numeric enable treated as set, pin ignored
					rsp_nxt.ne_effective = 1'b1;
					if (any_exc)
					begin
						rsp_nxt.fault = 1'b1;
						rsp_nxt.vector = VEC_SIMD_FP;
					end
				end
			end
			// one fault, and no commit when faulting
			rsp_nxt.commit = !rsp_nxt.fault;
		end
		else
			rsp_nxt.commit = req.valid;
	end

	// outcome register
	always_ff @(posedge clk or negedge rst_s2_r)
	begin
		if (!rst_s2_r)
			rsp_r <= '0;
		else
			rsp_r <= rsp_nxt;
	end

	// outcome straight from the flops, one cycle after the request
	assign rsp = rsp_r;

	// helper views of the previous request
	sfg_req_s req_q;
	always_ff @(posedge clk or negedge rst_s2_r)
	begin
		if (!rst_s2_r)
			req_q <= '0;
		else
			req_q <= req;
	end

	property p_ts_fault;
		@(posedge clk) disable iff (!rst_s2_r)
		req.valid && is_simd(req.cls) && feat_ok(req.cls, feature_identification) && !emu
		&& ts && req.cls != SFG_CLS_P2_FREE |=> rsp.fault && rsp.vector == VEC_DEV_UNAVAIL;
	endproperty
	a_ts_fault: assert property (p_ts_fault) else $error("missing device-unavailable");

	property p_feat_ud;
		@(posedge clk) disable iff (!rst_s2_r)
		req.valid && is_simd(req.cls) && !feat_ok(req.cls, feature_identification)
		|=> rsp.vector == VEC_INVALID_OP && !rsp.commit;
	endproperty
	a_feat_ud: assert property (p_feat_ud) else $error("missing feature invalid-opcode");

	property p_emu_ud;
		@(posedge clk) disable iff (!rst_s2_r)
		req.valid && is_simd(req.cls) && emu |=> rsp.vector == VEC_INVALID_OP;
	endproperty
	a_emu_ud: assert property (p_emu_ud) else $error("emulation flag not honoured");

	property p_free_no_nm;
		@(posedge clk) disable iff (!rst_s2_r)
		req.valid && req.cls == SFG_CLS_P2_FREE |=> rsp.vector != VEC_DEV_UNAVAIL;
	endproperty
	a_free_no_nm: assert property (p_free_no_nm) else $error("checksum class faulted");

	property p_no_fp_sup;
		@(posedge clk) disable iff (!rst_s2_r)
		req.valid && (req.cls == SFG_CLS_SUP3 || req.cls == SFG_CLS_P2_GATED)
		|=> rsp.exc == '0 && rsp.vector != VEC_SIMD_FP;
	endproperty
	a_no_fp_sup: assert property (p_no_fp_sup) else $error("fp error from integer class");

	property p_round_inv;
		@(posedge clk) disable iff (!rst_s2_r)
		req.valid && !req.src_snan && req.op == SFG_OP_ROUND |=> !rsp.exc.invalid && !rsp.exc.overflow;
	endproperty
	a_round_inv: assert property (p_round_inv) else $error("rounding invalid without snan");

	property p_round_prec;
		@(posedge clk) disable iff (!rst_s2_r)
		req.valid && req.op == SFG_OP_ROUND && req.imm[IMM_SUPPRESS_PREC] |=> !rsp.exc.precision;
	endproperty
	a_round_prec: assert property (p_round_prec) else $error("precision not suppressed");

	property p_fault_no_commit;
		@(posedge clk) disable iff (!rst_s2_r)
		rsp.fault |-> !rsp.commit && $past(req.valid);
	endproperty
	a_fault_no_commit: assert property (p_fault_no_commit) else $error("fault with commit");

	property p_move_quiet;
		@(posedge clk) disable iff (!rst_s2_r)
		req.valid && req.op == SFG_OP_FP_MOVE |=> rsp.exc == '0;
	endproperty
	a_move_quiet: assert property (p_move_quiet) else $error("blend or insert signalled");

	property p_dot_zero;
		@(posedge clk) disable iff (!rst_s2_r)
		rsp.valid && !rsp.fault && req_q.op == SFG_OP_DOT && is_simd(req_q.cls)
		|-> rsp.zero_lanes == ~req_q.imm[IMM_SEL_LO +: 4];
	endproperty
	a_dot_zero: assert property (p_dot_zero) else $error("dot lane zeroing wrong");

	// a selected NaN lane must reach the output
	property p_dot_nan;
		@(posedge clk) disable iff (!rst_s2_r)
		rsp.valid && !rsp.fault && req_q.op == SFG_OP_DOT && is_simd(req_q.cls)
		&& |(req_q.nan_in & req_q.imm[IMM_SEL_LO +: 4]) |-> rsp.force_nan;
	endproperty
	a_dot_nan: assert property (p_dot_nan) else $error("dot NaN not propagated");

	// the third-set truncating store never reports through the simd vector
	property p_legacy_store;
		@(posedge clk) disable iff (!rst_s2_r)
		req.valid && req.cls == SFG_CLS_EXT3 && req.op == SFG_OP_TRUNC_STORE
		|=> rsp.vector != VEC_SIMD_FP;
	endproperty
	a_legacy_store: assert property (p_legacy_store) else $error("store used simd vector");

	// third and supplemental sets, except the third-set truncating store, run with numeric enable forced on
	property p_ne_forced;
		@(posedge clk) disable iff (!rst_s2_r)
		req.valid && (req.cls == SFG_CLS_EXT3 || req.cls == SFG_CLS_SUP3)
		&& req.op != SFG_OP_TRUNC_STORE && feat_ok(req.cls, feature_identification)
		&& !emu && !ts |=> rsp.ne_effective;
	endproperty
	a_ne_forced: assert property (p_ne_forced) else $error("numeric enable not forced");

	// checksum and population count raise no fp condition either
	property p_free_quiet;
		@(posedge clk) disable iff (!rst_s2_r)
		req.valid && req.cls == SFG_CLS_P2_FREE |=> rsp.exc == '0;
	endproperty
	a_free_quiet: assert property (p_free_quiet) else $error("part two signalled fp");

	// a fault always carries one vector, and no vector stands without one
	property p_fault_vec;
		@(posedge clk) disable iff (!rst_s2_r)
		rsp.fault == (rsp.vector != VEC_NONE);
	endproperty
	a_fault_vec: assert property (p_fault_vec) else $error("fault and vector disagree");

	// main outcomes seen at the pipeline side
	c_nm: cover property (@(posedge clk) disable iff (!rst_s2_r) rsp.vector == VEC_DEV_UNAVAIL);
	c_ud: cover property (@(posedge clk) disable iff (!rst_s2_r) rsp.vector == VEC_INVALID_OP);
	c_xm: cover property (@(posedge clk) disable iff (!rst_s2_r) rsp.vector == VEC_SIMD_FP);
	c_mf: cover property (@(posedge clk) disable iff (!rst_s2_r) rsp.vector == VEC_LEGACY_FP);
	c_dot: cover property (@(posedge clk) disable iff (!rst_s2_r) rsp.commit && |rsp.zero_lanes);

endmodule

// >>> tb/sfg_pipe_model.sv
`timescale 1ns/1ns
// pipeline side: counts results that fault and still retire
module sfg_pipe_model
	import sfg_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// outcome from the gate
	input wire sfg_rsp_s rsp,
	// count of faulting results that retired
	output int bad_commits
);
	// a faulting result must leave the destination alone
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			bad_commits <= 0;
		else if (rsp.valid && rsp.fault && rsp.commit)
			bad_commits <= bad_commits + 1;
	end
endmodule

// >>> tb/simd_extension_fault_gating_tb.sv
`timescale 1ns/1ns
`define CHK(a, b) check_val(64'(a), 64'(b))
module simd_extension_fault_gating_tb;
	import sfg_pkg::*;
	logic clk;
	logic rst_n;
	logic [CTL_W-1:0] ctl;
	logic [FEAT_W-1:0] feat;
	logic [3:0] mask;
	logic ign_n;
	sfg_req_s req;
	sfg_rsp_s rsp;
	sfg_rsp_s exp_q[$]; // expected results in order
	sfg_req_s req_q[$]; // requests matching exp_q
	int bad_commits;
	int n_errors;
	int total_checks;
	int cyc;
	logic [31:0] seed;
	logic [31:0] r2;

	sfg_gate u_sfg_gate (.clk(clk), .rst_n(rst_n), .ctl_flags(ctl),
		.feature_identification(feat), .simd_control_status_mask(mask),
		.ignore_numeric_error_pin_n(ign_n), .req(req), .rsp(rsp));
	sfg_pipe_model u_sfg_pipe_model (.clk(clk), .rst_n(rst_n), .rsp(rsp),
		.bad_commits(bad_commits));

	// 100 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// hang guard
	initial
	begin
		cyc = 0;
		forever
		begin
			@(posedge clk);
			cyc++;
			if (cyc == 3000)
			begin
				n_errors++;
				summarize();
			end
		end
	end

	// random source
	function automatic logic [31:0] xs(logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	task automatic check_val(logic [63:0] a, logic [63:0] b);
		total_checks++;
		if (a !== b)
		begin
			n_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, a, b);
		end
	endtask

	// reference outcome from current flags
	function automatic sfg_rsp_s model(sfg_req_s r);
		sfg_rsp_s e;
		logic ok;
		logic legacy;
		logic any;
		logic [3:0] sel;
		e = '0;
		e.valid = r.valid;
		e.ne_effective = ctl[CTL_NE_BIT];
		sel = r.imm[7:4];
		legacy = r.cls == SFG_CLS_EXT3 && r.op == SFG_OP_TRUNC_STORE;
		case (r.cls)
			SFG_CLS_EXT3: ok = feat[FEAT_EXT3_BIT];
			SFG_CLS_SUP3: ok = feat[FEAT_SUP3_BIT];
			SFG_CLS_P1: ok = feat[FEAT_P1_BIT];
			SFG_CLS_P2_GATED: ok = feat[FEAT_P2_BIT];
			default: ok = 1'b1;
		endcase
		if (!r.valid || r.cls == SFG_CLS_OTHER)
			e.exc = '0;
		else if (!ok || ctl[CTL_EMU_BIT])
			{e.fault, e.vector} = {1'b1, VEC_INVALID_OP};
		else if (r.cls != SFG_CLS_P2_FREE && ctl[CTL_TS_BIT])
			{e.fault, e.vector} = {1'b1, VEC_DEV_UNAVAIL};
		else
		begin
			if (r.cls == SFG_CLS_EXT3 || (r.cls == SFG_CLS_P1 && r.op == SFG_OP_PLAIN))
				e.exc = r.raw_exc;
			if (r.cls == SFG_CLS_P1 && r.op == SFG_OP_DOT)
			begin
				e.exc = r.raw_exc & ~r.elem_input_exc;
				e.zero_lanes = ~sel;
				e.force_nan = |(r.nan_in & sel);
			end
			if (r.cls == SFG_CLS_P1 && r.op == SFG_OP_ROUND)
			begin
				e.exc.invalid = r.src_snan;
				e.exc.precision = r.raw_exc.precision & ~r.imm[IMM_SUPPRESS_PREC];
			end
			any = (e.exc.invalid & ~mask[0]) | (e.exc.denormal & ~mask[1])
				| ((e.exc.overflow | e.exc.underflow) & ~mask[2])
				| (e.exc.precision & ~mask[3]);
			// legacy store honours the control flag and the ignore pin
			e.ne_effective = legacy ? ctl[CTL_NE_BIT] : 1'b1;
			e.fault = any & (~legacy | ctl[CTL_NE_BIT] | ign_n);
			e.vector = !e.fault ? VEC_NONE : (legacy ? VEC_LEGACY_FP : VEC_SIMD_FP);
		end
		e.commit = r.valid & ~e.fault;
		return e;
	endfunction

	// compare one result against its expectation
	task automatic check_one();
		sfg_rsp_s e;
		sfg_req_s q;
		e = exp_q.pop_front();
		q = req_q.pop_front();
		`CHK(rsp.valid, e.valid);
		`CHK(rsp.fault, e.fault);
		`CHK(rsp.vector, e.vector);
		`CHK(rsp.commit, e.commit);
		if (q.op == SFG_OP_TRUNC_STORE)
			`CHK(rsp.vector == VEC_SIMD_FP, 1'b0);
		`CHK(rsp.exc, e.exc);
		`CHK({rsp.zero_lanes, rsp.force_nan}, {e.zero_lanes, e.force_nan});
		`CHK(rsp.ne_effective, e.ne_effective);
	endtask

	task automatic summarize();
		$display("errors=%0d checks=%0d", n_errors, total_checks);
		if (n_errors == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// main sequence: back-to-back random requests
	initial
	begin
		{rst_n, ctl, feat, mask, ign_n, req} = '0;
		n_errors = 0;
		total_checks = 0;
		seed = 32'h1C0;
		repeat (10) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		repeat (2) @(negedge clk);
		for (int i = 0; i < 800; i++)
		begin
			@(negedge clk);
			if (exp_q.size() > 0)
				check_one();
			seed = xs(seed);
			r2 = xs(seed);
			req = '0;
			req.valid = seed[31] | seed[30];
			req.cls = sfg_cls_e'(seed[2:0] % 3'h6);
			if (req.cls == SFG_CLS_EXT3 && seed[3])
				req.op = SFG_OP_TRUNC_STORE;
			if (req.cls == SFG_CLS_P1)
				req.op = seed[4:3] == 2'h0 ? SFG_OP_PLAIN : sfg_op_e'({1'b0, seed[4:3]} + 3'h1);
			req.imm = seed[12:5];
			req.nan_in = seed[16:13];
			req.raw_exc = seed[21:17];
			req.elem_input_exc = seed[26:22];
			req.src_snan = seed[27];
			if (req.op == SFG_OP_ROUND)
				req.raw_exc.invalid = seed[27];
			ctl = '0;
			ctl[CTL_EMU_BIT] = r2[0] & r2[1] & (req.cls != SFG_CLS_P2_FREE);
			ctl[CTL_TS_BIT] = r2[2];
			ctl[CTL_NE_BIT] = r2[3];
			feat = '1;
			feat[FEAT_EXT3_BIT] = r2[5] | r2[6];
			feat[FEAT_SUP3_BIT] = r2[7] | r2[8];
			feat[FEAT_P1_BIT] = r2[9] | r2[10];
			feat[FEAT_P2_BIT] = r2[11] | r2[12];
			mask = r2[16:13];
			ign_n = r2[17];
			exp_q.push_back(model(req));
			req_q.push_back(req);
		end
		@(negedge clk);
		check_one();
		`CHK(bad_commits, 0);
		summarize();
	end
endmodule
